// >>> sef_pkg.sv
// Constants and types shared by the serial front end of the EEPROM.
//------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------
package sef_pkg;

  //----------------------------------------------------------------
  // Instruction codes; bit 3 is a don't-care in every code.
  //----------------------------------------------------------------
  localparam logic [7:0] OP_DC_MASK = 8'hF7;  // Bits compared when decoding.
  localparam logic [7:0] OP_WREN    = 8'h06;  // Set the write enable latch.
  localparam logic [7:0] OP_WRDI    = 8'h04;  // Clear the write enable latch.
  localparam logic [7:0] OP_RDSR    = 8'h05;  // Read the status byte.
  localparam logic [7:0] OP_WRSR    = 8'h01;  // Write the status byte.
  localparam logic [7:0] OP_READ    = 8'h03;  // Read memory.
  localparam logic [7:0] OP_WRITE   = 8'h02;  // Write memory.

  //----------------------------------------------------------------
  // Bit counts within one frame.
  //----------------------------------------------------------------
  localparam int          CNT_W         = 6;      // Width of the saturating bit counter.
  localparam logic [5:0]  CNT_MAX       = 6'h3F;  // Counter saturates here.
  localparam logic [5:0]  CNT_OP_LAST   = 6'h07;  // Count before the last opcode bit.
  localparam logic [5:0]  CNT_OP_BITS   = 6'h08;  // Bits in an instruction.
  localparam logic [5:0]  CNT_WRSR_BITS = 6'h10;  // Opcode plus status byte.
  localparam logic [5:0]  CNT_WRITE_MIN = 6'h18;  // Opcode, address and one data byte.
  localparam logic [2:0]  BYTE_MASK     = 3'h7;   // Low count bits inside a byte.

  //----------------------------------------------------------------
  // Timing.
  //----------------------------------------------------------------
  localparam int CORE_CLK_KHZ                = 20000;  // Core clock rate.
  localparam int INTERNAL_WRITE_DURATION_US  = 4000;   // Longest internal write.
  // A longest time rounds down; the product here is exact.
  localparam int WRITE_CYCLES = INTERNAL_WRITE_DURATION_US * CORE_CLK_KHZ / 1000;
  localparam int TIMER_W      = 17;                    // Holds WRITE_CYCLES.
  localparam logic [16:0] TIMER_RST = 17'h00000;       // Timer value after reset.

  //----------------------------------------------------------------
  // Pin filter depth and core states.
  //----------------------------------------------------------------
  localparam int SYNC_N = 3;  // Flip-flops on each crossing input.

  typedef enum logic [2:0] {
    SEF_ST_STANDBY  = 3'h1,  // Deselected, no write running.
    SEF_ST_SELECTED = 3'h2,  // Chip select low, no write running.
    SEF_ST_WRITING  = 3'h4   // Internal write cycle timing out.
  } sef_state_e;

endpackage

// >>> sef_top.sv
// Serial front end: frame decode on the serial clock, write timing on the core clock.
`timescale 1ns/1ns

module sef_top #(
  parameter int WRITE_CYCLES_P = sef_pkg::WRITE_CYCLES  // Shorten for simulation.
) (
  input  wire logic CORE_CLK_I,             // Core clock, 20 MHz.
  input  wire logic RST_B_I,                // Asynchronous reset, active low.
  input  wire logic SCK_I,                  // Serial clock from the master.
  input  wire logic CS_B_I,                 // Chip select, active low.
  input  wire logic SI_I,                   // Serial data in.
  input  wire logic HOLD_B_I,               // Pause, active low.
  input  wire logic WP_B_I,                 // Write protect, active low.
  output logic      SO_O,                   // Serial data out.
  output logic      SO_OE_O,                // Serial data out drive enable.
  output logic      SELECTED_O,             // Device selected.
  output logic      STANDBY_O,              // Device in standby.
  output logic      WRITE_BUSY_O,           // Internal write in progress.
  output logic      WRITE_ENABLE_LATCH_O    // Write enable latch state.
);

  //----------------------------------------------------------------
  // Rising-edge frame state, cleared whenever chip select is high.
  //----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cnt;      // Bits taken in this frame, saturating.
    logic [7:0] shift;    // Incoming bits, MSB first.
    logic       ignore;   // Invalid opcode seen; rest of frame dropped.
    logic       rdsr;     // Status read decoded.
  } sef_frame_s;

  // Frame results that must survive deselection for the core side.
  typedef struct packed {
    logic [5:0] cnt;      // Final bit count of the last frame.
    logic [7:0] op;       // Opcode of the last frame.
    logic       seq;      // Toggles once at the first bit of each frame.
  } sef_result_s;

  // Falling-edge output state.
  typedef struct packed {
    logic [1:0] st_s1;    // First stage of the status synchroniser.
    logic [1:0] st_s2;    // Second stage, the one that is used.
    logic       so;       // Output data.
    logic       oe;       // Output drive enable.
  } sef_out_s;

  // Core-clock state.
  typedef struct packed {
    logic [2:0]          cs_sy;    // Chip select filter chain.
    logic [2:0]          wp_sy;    // Write protect filter chain.
    logic [2:0]          seq_sy;   // Frame toggle filter chain.
    logic                cs_f;     // Filtered chip select.
    logic                wp_f;     // Filtered write protect.
    logic                seq_f;    // Filtered frame toggle.
    logic                seq_seen; // Last frame toggle acted upon.
    sef_pkg::sef_state_e state;    // Core state.
    logic [16:0]         timer;    // Write cycle counter.
    logic                write_enable_latch;      // Write enable latch.
    logic                busy;     // Registered busy flag.
    logic                standby;  // Registered standby flag.
    logic                sel;      // Registered selected flag.
  } sef_core_s;

  sef_frame_s  fr_r,  fr_nxt;
  sef_result_s res_r, res_nxt;
  sef_out_s    out_r, out_nxt;
  sef_core_s   co_r,  co_nxt;

  logic [7:0] op_in;      // Opcode including the bit now arriving.
  logic       op_valid;   // That opcode is one of the known codes.

  //----------------------------------------------------------------
  // Opcode check; bit 3 is masked away before comparing.
  //----------------------------------------------------------------
  function automatic logic sef_is_op(input logic [7:0] a, input logic [7:0] b);
    sef_is_op = ((a & sef_pkg::OP_DC_MASK) == b);
  endfunction

  always_comb begin
    op_in    = {fr_r.shift[6:0], SI_I};
    op_valid = sef_is_op(op_in, sef_pkg::OP_WREN) | sef_is_op(op_in, sef_pkg::OP_WRDI) |
               sef_is_op(op_in, sef_pkg::OP_RDSR) | sef_is_op(op_in, sef_pkg::OP_WRSR) |
               sef_is_op(op_in, sef_pkg::OP_READ) | sef_is_op(op_in, sef_pkg::OP_WRITE);
  end

  //----------------------------------------------------------------
  // Link domain, rising edge: bit capture and opcode decode.
  //----------------------------------------------------------------
  // A paused or rejected frame leaves the frame and result registers untouched.
  always_comb begin
    fr_nxt  = fr_r;
    res_nxt = res_r;
    if (HOLD_B_I && !fr_r.ignore) begin  // and
      fr_nxt.shift = op_in;
      if (fr_r.cnt != sef_pkg::CNT_MAX) begin
        fr_nxt.cnt = fr_r.cnt + 6'h01;
      end
      // The first bit after select opens a new frame.
      if (fr_r.cnt == '0) begin
        res_nxt.seq = ~res_r.seq;
      end
      if (fr_r.cnt == sef_pkg::CNT_OP_LAST) begin
        res_nxt.op  = op_in;
        fr_nxt.ignore = ~op_valid;
        fr_nxt.rdsr   = sef_is_op(op_in, sef_pkg::OP_RDSR);
      end
      res_nxt.cnt = fr_nxt.cnt;
    end
  end

  // Chip select high clears the frame at once, so the next select starts clean.
  always_ff @(posedge SCK_I or negedge RST_B_I or posedge CS_B_I) begin
    if (!RST_B_I || CS_B_I) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Results stay put while chip select is high; the core reads them then.
  always_ff @(posedge SCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      res_r <= '0;
    end else if (!CS_B_I) begin
      res_r <= res_nxt;
    end
  end

  //----------------------------------------------------------------
  // Link domain, falling edge: serial output.
  //----------------------------------------------------------------
  // The status byte repeats until the bit count saturates at CNT_MAX; after that bit 0 stays on the output.
  always_comb begin
    out_nxt       = out_r;
    out_nxt.st_s1 = {co_r.write_enable_latch, co_r.busy};
    out_nxt.st_s2 = out_r.st_s1;
    if (!HOLD_B_I) begin
      out_nxt.oe = 1'b0;
    end else if (fr_r.rdsr && !fr_r.ignore && fr_r.cnt >= sef_pkg::CNT_OP_BITS) begin
      out_nxt.oe = 1'b1;
      // Bit 7 first; only the two low status bits are nonzero.
      case (~fr_r.cnt[2:0])
        3'h1:    out_nxt.so = out_r.st_s2[1];
        3'h0:    out_nxt.so = out_r.st_s2[0];
        default: out_nxt.so = 1'b0;
      endcase
    end else begin
      out_nxt.oe = 1'b0;
    end
  end

  // Synchroniser and output share the reset; refilling takes two edges,
  // well before the first status bit is due.
  always_ff @(negedge SCK_I or negedge RST_B_I or posedge CS_B_I) begin
    if (!RST_B_I || CS_B_I) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  //----------------------------------------------------------------
  // Core domain: pin filtering, command effects and write timing.
  //----------------------------------------------------------------
  // Frame words cross quasi-statically: they are only read after the
  // filtered chip select has gone high, when the serial clock stands still.
  always_comb begin
    co_nxt        = co_r;
    co_nxt.cs_sy  = {co_r.cs_sy[1:0], CS_B_I};
    co_nxt.wp_sy  = {co_r.wp_sy[1:0], WP_B_I};
    co_nxt.seq_sy = {co_r.seq_sy[1:0], res_r.seq};
    if (co_r.cs_sy[1] == co_r.cs_sy[2]) begin
      co_nxt.cs_f = co_r.cs_sy[2];
    end
    if (co_r.wp_sy[1] == co_r.wp_sy[2]) begin
      co_nxt.wp_f = co_r.wp_sy[2];
    end
    if (co_r.seq_sy[1] == co_r.seq_sy[2]) begin
      co_nxt.seq_f = co_r.seq_sy[2];
    end

    // Frame end: act on a frame that was really clocked.
    if (co_nxt.cs_f && !co_r.cs_f && (co_r.seq_f != co_r.seq_seen)) begin
      co_nxt.seq_seen = co_r.seq_f;
      if (res_r.cnt == sef_pkg::CNT_OP_BITS && sef_is_op(res_r.op, sef_pkg::OP_WREN)) begin
        co_nxt.write_enable_latch = 1'b1;
      end else if (res_r.cnt == sef_pkg::CNT_OP_BITS &&
                   sef_is_op(res_r.op, sef_pkg::OP_WRDI)) begin
        co_nxt.write_enable_latch = 1'b0;
      end else if (co_r.write_enable_latch && co_r.wp_f && co_r.state != sef_pkg::SEF_ST_WRITING &&
                   (res_r.cnt[2:0] & sef_pkg::BYTE_MASK) == 3'h0 &&
                   ((sef_is_op(res_r.op, sef_pkg::OP_WRSR) &&
                     res_r.cnt == sef_pkg::CNT_WRSR_BITS) ||
                    (sef_is_op(res_r.op, sef_pkg::OP_WRITE) &&
                     res_r.cnt >= sef_pkg::CNT_WRITE_MIN))) begin
        co_nxt.state = sef_pkg::SEF_ST_WRITING;
        co_nxt.timer = sef_pkg::TIMER_RST;
      end
    end

    case (co_r.state)
      sef_pkg::SEF_ST_STANDBY: begin
        if (!co_nxt.cs_f) begin
          co_nxt.state = sef_pkg::SEF_ST_SELECTED;
        end
      end
      sef_pkg::SEF_ST_SELECTED: begin
        if (co_nxt.cs_f && co_nxt.state != sef_pkg::SEF_ST_WRITING) begin
          co_nxt.state = sef_pkg::SEF_ST_STANDBY;
        end
      end
      sef_pkg::SEF_ST_WRITING: begin
        // Busy lasts the full duration; the latch drops when it ends.
        if (co_r.timer == 17'(WRITE_CYCLES_P - 1)) begin
          co_nxt.write_enable_latch = 1'b0;
          // Back to whichever state the filtered chip select calls for.
          if (co_nxt.cs_f) begin
            co_nxt.state = sef_pkg::SEF_ST_STANDBY;
          end else begin
            co_nxt.state = sef_pkg::SEF_ST_SELECTED;
          end
        end else begin
          co_nxt.timer = co_r.timer + 17'h00001;
        end
      end
      default: begin
        co_nxt.state = sef_pkg::SEF_ST_STANDBY;
      end
    endcase

    // Write protect overrides any latch set in the same cycle.
    if (!co_nxt.wp_f) begin
      co_nxt.write_enable_latch = 1'b0;
    end

    co_nxt.busy    = (co_nxt.state == sef_pkg::SEF_ST_WRITING);
    co_nxt.standby = (co_nxt.state == sef_pkg::SEF_ST_STANDBY);
    co_nxt.sel     = ~co_nxt.cs_f;
  end

  // Filters start at the idle pin levels so reset release raises no event.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      co_r          <= '0;
      co_r.cs_sy    <= 3'h7;
      co_r.wp_sy    <= 3'h7;
      co_r.cs_f     <= 1'b1;
      co_r.wp_f     <= 1'b1;
      co_r.state    <= sef_pkg::SEF_ST_STANDBY;
      co_r.timer    <= sef_pkg::TIMER_RST;
      co_r.standby  <= 1'b1;
    end else begin
      co_r <= co_nxt;
    end
  end

  //----------------------------------------------------------------
  // Outputs, each straight from a flip-flop.
  //----------------------------------------------------------------
  always_comb begin
    SO_O                 = out_r.so;
    SO_OE_O              = out_r.oe;
    SELECTED_O           = co_r.sel;
    STANDBY_O            = co_r.standby;
    WRITE_BUSY_O         = co_r.busy;
    WRITE_ENABLE_LATCH_O = co_r.write_enable_latch;
  end

endmodule

// >>> sef_top_assertions.sv
// Port-level checks on the serial front end, bound into its top module.
`timescale 1ns/1ns
module sef_top_assertions #(
  parameter int WRITE_CYCLES_P = 20  // Length of one internal write in core cycles.
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic SCK_I,
  input wire logic CS_B_I,
  input wire logic HOLD_B_I,
  input wire logic WP_B_I,
  input wire logic SO_O,
  input wire logic SO_OE_O,
  input wire logic SELECTED_O,
  input wire logic STANDBY_O,
  input wire logic WRITE_BUSY_O,
  input wire logic WRITE_ENABLE_LATCH_O
);
  int   busy_cnt_r;  // Core cycles the busy flag has stood high so far.
  logic so_rise_r;   // Serial output as it stood at the last rising edge.
  // Count the busy run, so its length can be judged at the falling edge of busy.
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy_cnt_r <= 0;
    end else begin
      busy_cnt_r <= WRITE_BUSY_O ? busy_cnt_r + 1 : 0;
    end
  end
  // Keep the output seen at each rising edge; it must still stand at the next fall.
  always_ff @(posedge SCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      so_rise_r <= 1'b0;
    end else begin
      so_rise_r <= SO_O;
    end
  end
  // Two clock domains are watched here, so every property names its own clock.
  // Select held long enough for the core filter to see it.
  sequence s_cs_low;
    $fell(CS_B_I) ##1 (!CS_B_I) [*5];
  endsequence
  // Two falling edges in a row with the pause input low.
  sequence s_hold_two;
    !HOLD_B_I ##1 !HOLD_B_I;
  endsequence
  a_float_unsel: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    CS_B_I && $past(CS_B_I) |-> !SO_OE_O) else $error("output driven while unselected");
  a_unsel_flag: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    CS_B_I [*6] |-> !SELECTED_O) else $error("selected flag while unselected");
  a_select_soon: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    s_cs_low |-> SELECTED_O) else $error("select not taken in time");
  a_standby_on: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    (!SELECTED_O && !WRITE_BUSY_O) [*2] |-> STANDBY_O) else $error("standby missing");
  a_standby_off: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    (SELECTED_O || WRITE_BUSY_O) [*2] |-> !STANDBY_O) else $error("standby while active");
  a_busy_length: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    $fell(WRITE_BUSY_O) |-> busy_cnt_r == WRITE_CYCLES_P) else $error("write length wrong");
  a_latch_at_end: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    $fell(WRITE_BUSY_O) |-> !WRITE_ENABLE_LATCH_O) else $error("latch kept after write");
  a_busy_needs_latch: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    $rose(WRITE_BUSY_O) |-> WRITE_ENABLE_LATCH_O) else $error("write started without latch");
  a_protect_clear: assert property (
    @(posedge CORE_CLK_I) disable iff (!RST_B_I)
    (!WP_B_I) [*6] |-> !WRITE_ENABLE_LATCH_O) else $error("latch set under protect");
  a_so_on_fall: assert property (
    @(negedge SCK_I) disable iff (!RST_B_I || CS_B_I) SO_OE_O |-> SO_O == so_rise_r)
    else $error("serial output moved on a rising edge");
  a_hold_float: assert property (
    @(negedge SCK_I) disable iff (!RST_B_I || CS_B_I) s_hold_two |-> !SO_OE_O)
    else $error("output driven while paused");
endmodule

bind sef_top sef_top_assertions #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) sef_top_assertions_i (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .SCK_I(SCK_I), .CS_B_I(CS_B_I),
  .HOLD_B_I(HOLD_B_I), .WP_B_I(WP_B_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O),
  .SELECTED_O(SELECTED_O), .STANDBY_O(STANDBY_O), .WRITE_BUSY_O(WRITE_BUSY_O),
  .WRITE_ENABLE_LATCH_O(WRITE_ENABLE_LATCH_O));

// >>> sef_master.sv
// Behavioural serial master that frames bytes towards the front end.
`timescale 1ns/1ns
module sef_master (
  output logic      sck_o,     // Serial clock, still outside frames.
  output logic      cs_b_o,    // Chip select, active low.
  output logic      si_o,      // Serial data towards the device.
  output logic      hold_b_o,  // Pause, active low.
  input  wire logic so_i,      // Serial data from the device.
  input  wire logic so_oe_i    // Device drives its output.
);
  logic [7:0] rd_r;       // Bits taken in during the last byte of a frame.
  logic       oe_seen_r;  // The device drove its output at some rising edge.
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    si_o = 1'b0;
    hold_b_o = 1'b1;
  end
  // One frame; a non-zero junk byte pauses the opcode and clocks junk meanwhile.
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] junk);
    oe_seen_r = 1'b0;
    cs_b_o = 1'b0;
    #200;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        si_o = q[i][b];
        #3 sck_o = 1'b1;
        // A floated output reads as the inverse of its level, so a missing drive shows.
        rd_r[b] = so_oe_i ? so_i : ~so_i;
        oe_seen_r = oe_seen_r | so_oe_i;
        #3 sck_o = 1'b0;
        if (i == 0 && b == 4 && junk != 8'h00) begin
          #1 hold_b_o = 1'b0;
          for (int k = 7; k >= 0; k--) begin
            si_o = junk[k];
            #3 sck_o = 1'b1;
            #3 sck_o = 1'b0;
          end
          #1 hold_b_o = 1'b1;
        end
      end
    end
    #3 cs_b_o = 1'b1;
    // A released line must not keep its last level.
    si_o = ~si_o;
    #200;
  endtask
endmodule

// >>> sef_top_bench.sv
// Self-checking bench for the serial front end against a small reference model.
`timescale 1ns/1ns
module sef_top_bench;
  logic        core_clk;    // Core clock, 50 ns period.
  logic        rst_b;       // Reset, active low.
  logic        wp_b;        // Write protect, active low.
  logic [16:0] seed;        // Random state.
  logic [7:0]  q[$];        // Bytes of the next frame.
  int          mismatches;  // Wrong values seen.
  int          n_tests;     // Comparisons made.
  int          exp_wel;     // Reference latch state.
  int          exp_busy;    // Reference write state.
  int          cyc;         // Cycles run, for the hang guard.
  wire logic   sck, cs_b, si, hold_b, so, so_oe, selected, standby, busy, write_enable_latch;
  logic [7:0]  ops[4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};  // Latch codes, ignored bit both ways.
  logic [7:0]  bad[4] = '{8'h07, 8'hF6, 8'h85, 8'hFF};  // Codes outside the set.
  sef_top #(.WRITE_CYCLES_P(20)) sef_top_i (
    .CORE_CLK_I(core_clk), .RST_B_I(rst_b), .SCK_I(sck), .CS_B_I(cs_b), .SI_I(si),
    .HOLD_B_I(hold_b), .WP_B_I(wp_b), .SO_O(so), .SO_OE_O(so_oe), .SELECTED_O(selected),
    .STANDBY_O(standby), .WRITE_BUSY_O(busy), .WRITE_ENABLE_LATCH_O(write_enable_latch));
  sef_master sef_master_i (.sck_o(sck), .cs_b_o(cs_b), .si_o(si), .hold_b_o(hold_b),
    .so_i(so), .so_oe_i(so_oe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard: far above the few hundred cycles the sequence needs.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic frame(input logic [7:0] junk);
    @(negedge core_clk);
    sef_master_i.xfer(q, junk);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic rdsr(input logic [7:0] junk);
    q = '{8'h05, 8'h00};
    frame(junk);
    check("status", sef_master_i.rd_r, {6'h00, exp_wel[0], exp_busy[0]});
  endtask
  task automatic flags();
    check("latch", {7'h00, write_enable_latch}, exp_wel[7:0]);
    check("standby", {7'h00, standby}, {7'h00, exp_busy == 0});
    check("selected", {7'h00, selected}, 8'h00);
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    seed = 17'h1670A;
    {mismatches, n_tests, exp_wel, exp_busy, cyc} = '0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    check("enable", {7'h00, so_oe}, 8'h00);
    flags();
    rdsr(8'h00);
    // Each latch code, then a status read to see it through the output.
    foreach (ops[i]) begin
      q = '{ops[i]};
      frame(8'h00);
      exp_wel = ops[i][1];
      flags();
      rdsr(8'h00);
    end
    // Unknown codes: the rest of the frame is ignored and nothing is driven.
    foreach (bad[i]) begin
      q = '{bad[i], 8'h05, 8'h00};
      frame(8'h00);
      check("driven", {7'h00, sef_master_i.oe_seen_r}, 8'h00);
      flags();
    end
    // A memory write with random address and data, watched through status.
    q = '{8'h06};
    frame(8'h00);
    exp_wel = 1;
    seed = lfsr(seed);
    q = '{8'h02, seed[7:0], seed[15:8]};
    @(negedge core_clk);
    sef_master_i.xfer(q, 8'h00);
    for (int k = 0; k < 10 && busy !== 1'b1; k++) @(negedge core_clk);
    exp_busy = 1;
    check("busy", {7'h00, busy}, 8'h01);
    flags();
    rdsr(8'h00);
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge core_clk);
    {exp_busy, exp_wel} = '0;
    check("busy", {7'h00, busy}, 8'h00);
    flags();
    // A pause with random junk clocked in mid-opcode must change nothing.
    seed = lfsr(seed);
    rdsr(seed[7:0] | 8'h01);
    // Protect clears the latch, blocks a new set and any write; a status read follows once protect is released.
    q = '{8'h06};
    frame(8'h00);
    exp_wel = 1;
    flags();
    wp_b = 1'b0;
    repeat (8) @(negedge core_clk);
    exp_wel = 0;
    flags();
    frame(8'h00);
    flags();
    q = '{8'h02, 8'h00, 8'hA5};
    frame(8'h00);
    check("busy", {7'h00, busy}, 8'h00);
    wp_b = 1'b1;
    rdsr(8'h00);
    summarize();
  end
endmodule
